// *** rtl/fput_trap.sv ***
// Exception sequencer for unimplemented floating-point and F-line traps
`timescale 1ns/1ps
`default_nettype none
module fput_trap (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rstn,
    // Instruction issue
    input  wire logic                  instr_valid,
    input  wire fput_pkg::fput_instr_t instr,
    // Pipeline drain state
    input  wire logic                  pipe_busy,
    input  wire logic                  wb_pending,
    input  wire logic                  wb_fault,
    input  wire logic                  exc_busy,
    // Return from the access error handler
    input  wire logic                  return_from_exception,
    // Current status register
    input  wire logic [15:0]           status_register,
    // Stack write port
    output logic                       stack_we,
    output fput_pkg::fput_stack_t      stack_wr,
    input  wire logic                  stack_ack,
    // Vector fetch port
    output logic                       vec_req,
    output logic [7:0]                 vec_num,
    input  wire logic                  vec_ack,
    input  wire logic [31:0]           vec_addr,
    // Prefetch port
    input  wire logic                  prefetch_done,
    // Results to the integer unit
    output logic                       access_err,
    output logic                       fp_pending,
    output logic                       sr_write,
    output logic [15:0]                sr_new,
    output logic                       handler_start,
    output logic [31:0]                handler_pc,
    output logic                       busy,
    // Legacy pins
    input  wire logic                  cache_disable_input,
    input  wire logic [2:0]            interrupt_level_inputs,
    input  wire logic                  scan_select_pin,
    output logic                       small_buffer_mode,
    output logic                       scan_select_out
);
    import fput_pkg::*;

    typedef enum logic [2:0] {
        S_IDLE, S_DRAIN, S_AERR, S_WAIT_RTE, S_ENTRY,
        S_FRAME, S_VECTOR, S_PREFETCH
    } fput_state_t;

    fput_state_t state, next_state;
    logic        is_fline, is_fp;
    logic [31:0] ea_calc;
    logic        is_fp_q, next_is_fp_q;
    logic [31:0] ea_q, next_ea_q;
    logic [31:0] pc_q, next_pc_q;
    logic [31:0] npc_q, next_npc_q;
    logic [15:0] sr_copy, next_sr_copy;
    logic [2:0]  widx, next_widx;
    logic        stack_we_q, next_stack_we;
    fput_stack_t stack_q, next_stack;
    logic        vec_req_q, next_vec_req;
    logic        aerr_q, next_aerr;
    logic        pend_q, next_pend;
    logic        srw_q, next_srw;
    logic [15:0] srn_q, next_srn;
    logic        hs_q, next_hs;
    logic [31:0] hpc_q, next_hpc;
    logic        scan_s1, scan_s2;
    logic        fault_seen, next_fault_seen;
    logic        busy_q, next_busy;
    logic [7:0]  vec_num_q;

    fput_decode u_decode (
        .instr    (instr),
        .is_fline (is_fline),
        .is_fp    (is_fp),
        .ea       (ea_calc)
    );

    // Frame word selection; the vector offset word carries format and vector
    function automatic logic [31:0] frame_word(input logic [2:0] i,
                                               input logic       fp,
                                               input logic [15:0] sr,
                                               input logic [31:0] npc,
                                               input logic [31:0] ea,
                                               input logic [31:0] fpc);
        logic [15:0] vo;
        vo = {(fp ? FMT_FP_UNIMP : FMT_NORMAL), 2'b00, VEC_FLINE, 2'b00};
        case (i)
            3'd0:    frame_word = {sr, npc[31:16]};
            3'd1:    frame_word = {npc[15:0], vo};
            3'd2:    frame_word = ea;
            3'd3:    frame_word = fpc;
            default: frame_word = 32'h0000_0000;
        endcase
    endfunction

    // ======================================================================
    // Sequencer
    always_comb begin
        next_state      = state;
        next_is_fp_q    = is_fp_q;
        next_ea_q       = ea_q;
        next_pc_q       = pc_q;
        next_npc_q      = npc_q;
        next_sr_copy    = sr_copy;
        next_widx       = widx;
        next_stack_we   = 1'b0;
        next_stack      = stack_q;
        next_vec_req    = vec_req_q;
        next_aerr       = 1'b0;
        next_pend       = pend_q;
        next_srw        = 1'b0;
        next_srn        = srn_q;
        next_hs         = 1'b0;
        next_hpc        = hpc_q;
        next_fault_seen = fault_seen;
        case (state)
            S_IDLE: begin
                if (instr_valid && is_fline) begin
                    next_is_fp_q    = is_fp;
                    next_ea_q       = is_fp ? ea_calc : EA_NONE;
                    next_pc_q       = instr.pc;
                    next_npc_q      = instr.next_pc;
                    next_fault_seen = 1'b0;
                    next_state      = S_DRAIN;
                end
            end
            S_DRAIN: begin
                if (wb_fault && is_fp_q) begin
                    next_fault_seen = 1'b1;
                end
                if (!pipe_busy && !wb_pending && !exc_busy) begin
                    if (fault_seen || (wb_fault && is_fp_q)) begin
                        next_state = S_AERR;
                    end else begin
                        next_state = S_ENTRY;
                    end
                end
            end
            S_AERR: begin
                next_aerr  = 1'b1;
                next_pend  = 1'b1;
                next_state = S_WAIT_RTE;
            end
            S_WAIT_RTE: begin
                if (return_from_exception) begin
                    next_pend       = 1'b0;
                    next_fault_seen = 1'b0;
                    next_state      = S_ENTRY;
                end
            end
            S_ENTRY: begin
                next_sr_copy = status_register;
                next_srn     = status_register;
                next_srn[SR_BIT_S]  = 1'b1;
                next_srn[SR_BIT_T1] = 1'b0;
                next_srn[SR_BIT_T0] = 1'b0;
                next_srw     = 1'b1;
                next_widx    = 3'd0;
                next_state   = S_FRAME;
            end
            S_FRAME: begin
                if (!stack_we_q || stack_ack) begin
                    if (stack_we_q && ((!is_fp_q && widx == 3'd2) ||
                                       (is_fp_q && widx == 3'd4))) begin
                        next_vec_req = 1'b1;
                        next_state   = S_VECTOR;
                    end else begin
                        next_stack_we    = 1'b1;
                        next_stack.index = widx;
                        next_stack.data  = frame_word(widx, is_fp_q,
                                               sr_copy, npc_q, ea_q, pc_q);
                        next_widx        = widx + 3'd1;
                    end
                end else begin
                    next_stack_we = 1'b1;
                end
            end
            S_VECTOR: begin
                if (vec_ack) begin
                    next_vec_req = 1'b0;
                    next_hpc     = vec_addr;
                    next_state   = S_PREFETCH;
                end
            end
            S_PREFETCH: begin
                if (prefetch_done) begin
                    next_hs    = 1'b1;
                    next_state = S_IDLE;
                end
            end
            default: next_state = S_IDLE;
        endcase
        // Busy is registered so that the port comes from a flop
        next_busy = (next_state != S_IDLE);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state      <= S_IDLE;
            is_fp_q    <= 1'b0;
            ea_q       <= EA_NONE;
            pc_q       <= 32'h0000_0000;
            npc_q      <= 32'h0000_0000;
            sr_copy    <= SR_RESET;
            widx       <= 3'd0;
            stack_we_q <= 1'b0;
            stack_q    <= '0;
            vec_req_q  <= 1'b0;
            aerr_q     <= 1'b0;
            pend_q     <= 1'b0;
            srw_q      <= 1'b0;
            srn_q      <= SR_RESET;
            hs_q       <= 1'b0;
            hpc_q      <= 32'h0000_0000;
            fault_seen <= 1'b0;
            busy_q     <= 1'b0;
            vec_num_q  <= VEC_FLINE;
        end else begin
            state      <= next_state;
            is_fp_q    <= next_is_fp_q;
            ea_q       <= next_ea_q;
            pc_q       <= next_pc_q;
            npc_q      <= next_npc_q;
            sr_copy    <= next_sr_copy;
            widx       <= next_widx;
            stack_we_q <= next_stack_we;
            stack_q    <= next_stack;
            vec_req_q  <= next_vec_req;
            aerr_q     <= next_aerr;
            pend_q     <= next_pend;
            srw_q      <= next_srw;
            srn_q      <= next_srn;
            hs_q       <= next_hs;
            hpc_q      <= next_hpc;
            fault_seen <= next_fault_seen;
            busy_q     <= next_busy;
            vec_num_q  <= VEC_FLINE;
        end
    end

    // ======================================================================
    // Legacy pins
    // scan select kept
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            scan_s1 <= 1'b0;
            scan_s2 <= 1'b0;
        end else begin
            scan_s1 <= scan_select_pin;
            scan_s2 <= scan_s1;
        end
    end

    // fixed small buffers
    // Cache disable and interrupt level inputs reach no logic; small buffer mode is always set
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            small_buffer_mode <= 1'b1;
        end else begin
            small_buffer_mode <= 1'b1;
        end
    end

    assign stack_we        = stack_we_q;
    assign stack_wr        = stack_q;
    assign vec_req         = vec_req_q;
    assign vec_num         = vec_num_q;
    assign access_err      = aerr_q;
    assign fp_pending      = pend_q;
    assign sr_write        = srw_q;
    assign sr_new          = srn_q;
    assign handler_start   = hs_q;
    assign handler_pc      = hpc_q;
    assign busy            = busy_q;
    assign scan_select_out = scan_s2;

endmodule
`default_nettype wire

// *** rtl/fput_pkg.sv ***
// Package: constants and carrier types of the floating-point trap unit
// ==========================================================================
package fput_pkg;

    // ======================================================================
    // Frame, vector, status register and prefetch constants
    localparam logic [3:0]  FMT_FP_UNIMP   = 4'h4;
    localparam logic [3:0]  FMT_NORMAL     = 4'h0;
    localparam logic [7:0]  VEC_FLINE      = 8'h0B;
    localparam logic [31:0] EA_NONE        = 32'h0000_0000;
    localparam int          FRAME_WORDS_FP = 8;
    localparam int          FRAME_WORDS_NM = 4;
    localparam int          SR_BIT_T1      = 15;
    localparam int          SR_BIT_T0      = 14;
    localparam int          SR_BIT_S       = 13;
    localparam logic [15:0] SR_RESET       = 16'h2700;
    localparam logic [3:0]  PREFETCH_WORDS = 4'h3;

    // ======================================================================
    // Effective address mode codes (bits 5:3 of the opcode)
    localparam logic [2:0] MODE_DREG = 3'h0;
    localparam logic [2:0] MODE_AREG = 3'h1;
    localparam logic [2:0] MODE_IND  = 3'h2;
    localparam logic [2:0] MODE_POST = 3'h3;
    localparam logic [2:0] MODE_PRE  = 3'h4;
    localparam logic [2:0] MODE_DISP = 3'h5;
    localparam logic [2:0] MODE_EXT  = 3'h7;

    // Decoded instruction handed from the pipeline
    typedef struct packed {
        logic [15:0] opword;
        logic [15:0] ext0;
        logic [31:0] addr_reg;
        logic [31:0] pc;
        logic [31:0] next_pc;
        logic [2:0]  size_bytes;
    } fput_instr_t;

    // One stack write: word index and long-word data
    typedef struct packed {
        logic [2:0]  index;
        logic [31:0] data;
    } fput_stack_t;

endpackage

// *** rtl/fput_decode.sv ***
// Partial decoder: class of an F-line opcode and its operand address
`timescale 1ns/1ps
`default_nettype none
module fput_decode (
    // Instruction
    input  wire fput_pkg::fput_instr_t instr,
    // Decode results
    output logic                       is_fline,
    output logic                       is_fp,
    output logic [31:0]                ea
);
    import fput_pkg::*;

    logic [2:0] mode;
    logic [2:0] reg_f;
    logic [2:0] cpid;

    assign mode  = instr.opword[5:3];
    assign reg_f = instr.opword[2:0];
    assign cpid  = instr.opword[11:9];

    always_comb begin
        is_fline = (instr.opword[15:12] == 4'hF);
        // fp class
        // Coprocessor id 1 with any type field (bits 8:6) other than 6 or 7
        is_fp = is_fline && (cpid == 3'h1) &&
                (instr.opword[8:6] != 3'h6) && (instr.opword[8:6] != 3'h7);
        case (mode)
            MODE_IND:  ea = instr.addr_reg;
            MODE_POST: ea = instr.addr_reg;
            MODE_PRE:  ea = instr.addr_reg - {29'h0, instr.size_bytes};
            MODE_DISP: ea = instr.addr_reg
                            + {{16{instr.ext0[15]}}, instr.ext0};
            MODE_EXT: begin
                if (reg_f == 3'h0) begin
                    ea = {{16{instr.ext0[15]}}, instr.ext0};
                end else if (reg_f == 3'h2) begin
                    ea = instr.pc + 32'h0000_0002
                         + {{16{instr.ext0[15]}}, instr.ext0};
                end else begin
                    ea = EA_NONE;
                end
            end
            default:   ea = EA_NONE;
        endcase
    end

endmodule
`default_nettype wire

// *** dv/fput_trap_checker.sv ***
// Checker: timing relations at the ports of the floating-point trap unit
`timescale 1ns/1ps
`default_nettype none
module fput_trap_checker (
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  rstn,
    // Drain and fault inputs
    input wire logic                  pipe_busy,
    input wire logic                  wb_pending,
    input wire logic                  exc_busy,
    input wire logic                  return_from_exception,
    input wire logic [15:0]           status_register,
    // Frame, vector and handler ports
    input wire logic                  stack_we,
    input wire fput_pkg::fput_stack_t stack_wr,
    input wire logic                  stack_ack,
    input wire logic                  vec_req,
    input wire logic [7:0]            vec_num,
    input wire logic                  vec_ack,
    input wire logic                  prefetch_done,
    input wire logic                  access_err,
    input wire logic                  fp_pending,
    input wire logic                  sr_write,
    input wire logic [15:0]           sr_new,
    input wire logic                  handler_start,
    // Legacy pins
    input wire logic                  small_buffer_mode,
    input wire logic                  scan_select_pin,
    input wire logic                  scan_select_out
);
    import fput_pkg::*;
    // ======================================================================
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_vec_num; vec_req |-> vec_num == VEC_FLINE; endproperty
    a_vec_num: assert property (p_vec_num)
        else $error("vector number is not the F-line vector");
    property p_vec_hold; vec_req && !vec_ack |=> vec_req; endproperty
    a_vec_hold: assert property (p_vec_hold)
        else $error("vector request dropped before acknowledge");
    property p_sr_new;
        sr_write |-> sr_new == {3'b001, $past(status_register[12:0])};
    endproperty
    a_sr_new: assert property (p_sr_new)
        else $error("new status lacks supervisor or keeps trace bits");
    property p_drained;
        sr_write |-> $past(!pipe_busy && !wb_pending && !exc_busy);
    endproperty
    a_drained: assert property (p_drained)
        else $error("exception entry while earlier work still running");
    property p_stack_hold;
        stack_we && !stack_ack |=> stack_we && $stable(stack_wr);
    endproperty
    a_stack_hold: assert property (p_stack_hold)
        else $error("stack write changed before acknowledge");
    property p_vo_word;
        stack_we && stack_wr.index == 3'd1 |->
            stack_wr.data[11:0] == {2'b00, VEC_FLINE, 2'b00};
    endproperty
    a_vo_word: assert property (p_vo_word)
        else $error("vector offset word malformed");
    property p_handler;
        handler_start |-> $past(prefetch_done) || $past(prefetch_done, 2);
    endproperty
    a_handler: assert property (p_handler)
        else $error("handler started before pipeline refill");
    property p_access; access_err |-> ##[0:1] fp_pending; endproperty
    a_access: assert property (p_access)
        else $error("access error without pending trap mark");
    property p_pend_hold;
        fp_pending && !return_from_exception |=> fp_pending;
    endproperty
    a_pend_hold: assert property (p_pend_hold)
        else $error("pending trap mark lost before handler return");
    property p_small; small_buffer_mode; endproperty
    a_small: assert property (p_small)
        else $error("small buffer mode not held");
    property p_scan;
        $past(rstn, 2) && $past(rstn) |->
            scan_select_out == $past(scan_select_pin, 2);
    endproperty
    a_scan: assert property (p_scan)
        else $error("scan select path altered");
endmodule

bind fput_trap fput_trap_checker i_chk (
    .clk, .rstn, .pipe_busy, .wb_pending, .exc_busy,
    .return_from_exception, .status_register, .stack_we, .stack_wr,
    .stack_ack, .vec_req, .vec_num, .vec_ack, .prefetch_done, .access_err,
    .fp_pending, .sr_write, .sr_new, .handler_start, .small_buffer_mode,
    .scan_select_pin, .scan_select_out
);
`default_nettype wire

// *** dv/tb_fp_unimplemented_trap.sv ***
// Testbench: directed traps, drain, write-back fault and legacy pins
`timescale 1ns/1ps
`default_nettype none
module tb_fp_unimplemented_trap;
    import fput_pkg::*;
    // ======================================================================
    // Signals and fixed stimulus values
    localparam logic [15:0] STATUS_USER = 16'hC015;
    localparam logic [31:0] AREG        = 32'h0000_8000;
    localparam logic [31:0] HVEC        = 32'h0000_4000;
    localparam logic [31:0] FAULT_ADDR  = 32'h0000_1000;
    localparam logic [31:0] NEXT_ADDR   = 32'h0000_1004;
    logic        clk, rstn, instr_valid, pipe_busy, wb_pending, wb_fault;
    logic        exc_busy, return_from_exception, stack_ack, vec_ack;
    logic        prefetch_done, cache_disable_input, scan_select_pin;
    logic        stack_we, vec_req, access_err, fp_pending, sr_write;
    logic        handler_start, busy, small_buffer_mode, scan_select_out;
    logic [2:0]  interrupt_level_inputs;
    logic [7:0]  vec_num;
    logic [15:0] status_register, sr_new;
    logic [31:0] vec_addr, handler_pc;
    fput_instr_t instr;
    fput_stack_t stack_wr;
    int          n_mismatch, total_checks;

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    fput_trap i_dut (
        .clk, .rstn, .instr_valid, .instr, .pipe_busy, .wb_pending,
        .wb_fault, .exc_busy, .return_from_exception, .status_register,
        .stack_we, .stack_wr, .stack_ack, .vec_req, .vec_num, .vec_ack,
        .vec_addr, .prefetch_done, .access_err, .fp_pending, .sr_write,
        .sr_new, .handler_start, .handler_pc, .busy, .cache_disable_input,
        .interrupt_level_inputs, .scan_select_pin, .small_buffer_mode,
        .scan_select_out
    );

    // ======================================================================
    // Shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Drain inputs stay up for hold cycles; entry must wait for them
    task automatic issue(input logic [15:0] op, input logic [15:0] ext,
                         input logic [2:0] drain, input int hold);
        @(negedge clk);
        instr.opword = op;
        instr.ext0 = ext;
        {pipe_busy, wb_pending, exc_busy} = drain;
        instr_valid = 1'b1;
        @(negedge clk);
        instr_valid = 1'b0;
        repeat (hold) begin
            check(sr_write, 1'b0);
            @(negedge clk);
        end
        {pipe_busy, wb_pending, exc_busy} = 3'b000;
    endtask

    task automatic frame(input logic fp, input logic [31:0] ea);
        logic [15:0] vo;
        logic [31:0] w [4];
        vo = {fp ? FMT_FP_UNIMP : FMT_NORMAL, 2'b00, VEC_FLINE, 2'b00};
        w = '{{STATUS_USER, NEXT_ADDR[31:16]}, {NEXT_ADDR[15:0], vo},
              ea, FAULT_ADDR};
        repeat (40) if (sr_write !== 1'b1) @(negedge clk);
        check(sr_write, 1'b1);
        check(sr_new, {3'b001, STATUS_USER[12:0]});
        for (int i = 0; i < (fp ? 4 : 2); i++) begin
            repeat (40) if (stack_we !== 1'b1) @(negedge clk);
            check(stack_wr.index, 32'(i));
            check(stack_wr.data, w[i]);
            stack_ack = 1'b1;
            @(negedge clk);
            stack_ack = 1'b0;
        end
        repeat (40) if (vec_req !== 1'b1) @(negedge clk);
        check(vec_req, 1'b1);
        check(stack_we, 1'b0);
        check(vec_num, VEC_FLINE);
        vec_ack = 1'b1;
        @(negedge clk);
        vec_ack = 1'b0;
        prefetch_done = 1'b1;
        @(negedge clk);
        prefetch_done = 1'b0;
        repeat (4) if (handler_start !== 1'b1) @(negedge clk);
        check(handler_start, 1'b1);
        check(handler_pc, HVEC);
        @(negedge clk);
        check(busy, 1'b0);
    endtask

    // ======================================================================
    // Scenarios
    task automatic s_fp_modes();
        issue(16'hF210, 16'h0000, 3'b111, 5);
        frame(1'b1, AREG);
        issue(16'hF200, 16'h0000, 3'b000, 0);
        frame(1'b1, EA_NONE);
        issue(16'hF23C, 16'h0000, 3'b010, 2);
        frame(1'b1, EA_NONE);
        issue(16'hF228, 16'hFFFC, 3'b001, 1);
        frame(1'b1, AREG - 32'h0000_0004);
    endtask

    task automatic s_fline();
        issue(16'hF000, 16'h0000, 3'b000, 0);
        frame(1'b0, EA_NONE);
        issue(16'hF3C0, 16'h0000, 3'b000, 0);
        frame(1'b0, EA_NONE);
        issue(16'h4E71, 16'h0000, 3'b000, 0);
        repeat (4) @(negedge clk);
        check(busy, 1'b0);
    endtask

    task automatic s_fault();
        @(negedge clk);
        instr.opword = 16'hF210;
        wb_pending = 1'b1;
        instr_valid = 1'b1;
        @(negedge clk);
        instr_valid = 1'b0;
        wb_fault = 1'b1;
        @(negedge clk);
        wb_fault = 1'b0;
        wb_pending = 1'b0;
        repeat (4) if (access_err !== 1'b1) @(negedge clk);
        check(access_err, 1'b1);
        repeat (6) @(negedge clk);
        check(fp_pending, 1'b1);
        check(sr_write, 1'b0);
        return_from_exception = 1'b1;
        @(negedge clk);
        return_from_exception = 1'b0;
        frame(1'b1, AREG);
    endtask

    task automatic s_legacy();
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            interrupt_level_inputs = 3'(i);
            scan_select_pin = i[0];
            @(negedge clk);
            check(scan_select_out, 1'(~i[0]));
            @(negedge clk);
            check(small_buffer_mode, 1'b1);
            check(scan_select_out, i[0]);
        end
        // Reset released with cache disable high must change nothing
        cache_disable_input = 1'b1;
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        check(sr_new, 16'h2700);
        check(small_buffer_mode, 1'b1);
        issue(16'hF210, 16'h0000, 3'b000, 0);
        frame(1'b1, AREG);
        cache_disable_input = 1'b0;
    endtask

    // ======================================================================
    // Main sequence and watchdog
    initial begin
        rstn = 1'b0;
        {instr_valid, pipe_busy, wb_pending, wb_fault, exc_busy} = '0;
        {return_from_exception, stack_ack, vec_ack, prefetch_done} = '0;
        cache_disable_input = 1'b0;
        scan_select_pin = 1'b1;
        interrupt_level_inputs = 3'b000;
        status_register = STATUS_USER;
        vec_addr = HVEC;
        instr = '0;
        instr.addr_reg = AREG;
        instr.pc = FAULT_ADDR;
        instr.next_pc = NEXT_ADDR;
        instr.size_bytes = 3'd4;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        s_fp_modes();
        s_fline();
        s_fault();
        s_legacy();
        tally_and_finish();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        #200_000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
